// >>> design/baud_gen.v
// Purpose: bit-rate tick generator, clk / (prescale * (divisor + 1))
// Assumes: prescale_i is never zero
// Notes:   restart_i clears both stages at once
`timescale 1ns/10ps
`default_nettype none

module baud_gen #(
  parameter DW = 16,
  parameter PW = 7
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // control
  input  wire          run_i,
  input  wire          restart_i,
  input  wire [DW-1:0] divisor_i,
  input  wire [PW-1:0] prescale_i,
  // output
  output reg           tick_o
);

  reg  [PW-1:0] pre_q;
  reg  [DW-1:0] cnt_q;
  wire          pre_end;

  assign pre_end = (pre_q >= prescale_i - {{(PW-1){1'b0}}, 1'b1});

  always @(posedge clk_i) begin
    if (rst_i || restart_i || !run_i) begin
      pre_q  <= {PW{1'b0}};
      cnt_q  <= {DW{1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (pre_end) begin
        pre_q <= {PW{1'b0}};
        // compare against the live divisor so a new value takes hold at once
        if (cnt_q >= divisor_i) begin
          cnt_q  <= {DW{1'b0}};
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
        end
      end else begin
        pre_q <= pre_q + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// >>> design/char_hold.v
// Purpose: one-entry character holding register with full flag
// Assumes: loader and taker share clk_i
// Notes:   a load in the same cycle as a take refills the entry
`timescale 1ns/10ps
`default_nettype none

module char_hold #(
  parameter W = 9
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // fill side
  input  wire         load_i,
  input  wire [W-1:0] data_i,
  // drain side
  input  wire         take_i,
  output reg  [W-1:0] data_o,
  output reg          full_o,
  output wire         drop_o
);

  // a load into a full entry that is not drained loses the new character
  assign drop_o = load_i & full_o & ~take_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= {W{1'b0}};
      full_o <= 1'b0;
    end else begin
      if (load_i & ~drop_o) begin
        data_o <= data_i;
      end
      // set wins over the take
      if (load_i) begin
        full_o <= 1'b1;
      end else if (take_i) begin
        full_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// >>> design/uart_baud_and_data_regs.v
// Purpose: data registers and baud generator of a serial port, APB slave
// Assumes: shifters sit outside on clk_i and use the char ports below
// Notes:   zero-wait APB, unmapped addresses answer pslverr
//
// What this block does
// - received low byte is readable, ninth bit lives in receive control status
// - received character held while next one shifts in, ninth bit included
// - transmit character held while previous one shifts, ninth bit included
// - writing divisor low byte restarts the baud counter immediately
// - writing divisor high byte restarts the baud counter immediately
// - divisor high byte ignored unless wide divisor select is set
// - rate is clock over 64, 16 or 4 times divisor plus one
// - mode bit set means synchronous, clear means asynchronous
// - wide select set uses sixteen-bit divisor, clear uses eight-bit
// - asynchronous high speed select chooses faster division
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "uart_baud_regs.vh"

module uart_baud_and_data_regs (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output wire        pslverr_o,
  // receive shifter side
  input  wire        rx_char_valid_i,
  input  wire [8:0]  rx_char_i,
  input  wire        rx_frame_err_i,
  input  wire        rx_idle_i,
  // transmit shifter side
  output wire        tx_char_valid_o,
  output wire [8:0]  tx_char_o,
  input  wire        tx_char_ready_i,
  input  wire        tx_shift_empty_i,
  // configuration seen by the shifters
  output wire        baud_tick_o,
  output wire        sync_mode_o,
  output wire        port_enable_o,
  output wire        tx_enable_o,
  output wire        rx_enable_o,
  output wire        clk_master_o,
  output wire        tx_nine_bit_o,
  output wire        rx_nine_bit_o,
  // interrupt
  output wire        irq_o
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  reg  [7:0]            div_low_q;
  reg  [7:0]            div_high_q;
  reg  [7:0]            rx_ctrl_q;
  reg  [7:0]            tx_ctrl_q;
  reg  [7:0]            baud_ctrl_q;
  reg                   overrun_q;
  reg                   frame_err_q;
  reg  [`IRQ_WIDTH-1:0] irq_stat_q;
  reg  [`IRQ_WIDTH-1:0] irq_en_q;
  reg  [7:0]            tx_last_q;
  reg                   rx_armed_q;

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  wire acc;
  wire wr;
  wire rd;
  reg  mapped;

  // every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign acc       = psel_i & penable_i;
  assign wr        = acc & pwrite_i & mapped;
  assign rd        = acc & ~pwrite_i & mapped;
  assign pslverr_o = acc & ~mapped;

  always @* begin
    case (paddr_i)
      `OFS_RECEIVE_DATA,
      `OFS_TRANSMIT_DATA,
      `OFS_BAUD_DIV_LOW,
      `OFS_BAUD_DIV_HIGH,
      `OFS_RX_CTRL_STATUS,
      `OFS_TX_CTRL_STATUS,
      `OFS_BAUD_CONTROL,
      `OFS_IRQ_STATUS,
      `OFS_IRQ_CLEAR,
      `OFS_IRQ_ENABLE: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  end

  wire wr_div_low;
  wire wr_div_high;
  wire wr_tx_data;
  wire rd_rx_data;

  assign wr_div_low  = wr & (paddr_i == `OFS_BAUD_DIV_LOW);
  assign wr_div_high = wr & (paddr_i == `OFS_BAUD_DIV_HIGH);
  assign wr_tx_data  = wr & (paddr_i == `OFS_TRANSMIT_DATA);
  assign rd_rx_data  = rd & (paddr_i == `OFS_RECEIVE_DATA);

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  wire sync_mode;
  wire high_speed;
  wire wide_div;

  assign sync_mode  = tx_ctrl_q[`TXC_SYNC_MODE];
  assign high_speed = tx_ctrl_q[`TXC_HIGH_SPEED];
  assign wide_div   = baud_ctrl_q[`BDC_WIDE_DIV];

  assign sync_mode_o   = sync_mode;
  assign port_enable_o = rx_ctrl_q[`RXC_PORT_EN];
  assign tx_enable_o   = tx_ctrl_q[`TXC_TX_EN];
  assign rx_enable_o   = rx_ctrl_q[`RXC_CONT_RX] | rx_ctrl_q[`RXC_SINGLE_RX];
  assign clk_master_o  = tx_ctrl_q[`TXC_CLK_MASTER];
  assign tx_nine_bit_o = tx_ctrl_q[`TXC_NINE_BIT];
  assign rx_nine_bit_o = rx_ctrl_q[`RXC_NINE_BIT];

  // --------------------------------------------------------------------------
  // baud rate generator
  // --------------------------------------------------------------------------
  reg  [6:0]  prescale;
  wire [15:0] divisor;

  // high byte only counts with the wide generator
  assign divisor = wide_div ? {div_high_q, div_low_q} : {8'h00, div_low_q};

  always @* begin
    if (sync_mode) begin
      prescale = `PRESCALE_FAST;
    end else begin
      case ({wide_div, high_speed})
        2'b00:   prescale = `PRESCALE_SLOW;
        2'b11:   prescale = `PRESCALE_FAST;
        default: prescale = `PRESCALE_MID;
      endcase
    end
  end

  // prescaler and divisor counter both restart on a divisor write, so the
  // first tick after a write comes one full period later; a mode change alone
  // does not restart them, so the period in flight may come out odd
  baud_gen #(
    .DW (16),
    .PW (7)
  ) u_baud_gen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (port_enable_o),
    .restart_i  (wr_div_low | wr_div_high),
    .divisor_i  (divisor),
    .prescale_i (prescale),
    .tick_o     (baud_tick_o)
  );

  // --------------------------------------------------------------------------
  // receive holding register
  // --------------------------------------------------------------------------
  wire       rx_load;
  wire [8:0] rx_held;
  wire       rx_full;
  wire       rx_drop;

  // characters are only accepted while the port and the receiver run
  assign rx_load = rx_char_valid_i & port_enable_o & rx_enable_o;

  char_hold #(
    .W (9)
  ) u_rx_hold (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (rx_load),
    .data_i (rx_char_i),
    .take_i (rd_rx_data & rx_armed_q),
    .data_o (rx_held),
    .full_o (rx_full),
    .drop_o (rx_drop)
  );

  // --------------------------------------------------------------------------
  // transmit holding register
  // --------------------------------------------------------------------------
  wire tx_take;

  assign tx_take = tx_char_valid_o & tx_char_ready_i;
  // a write while the entry is still full and not being taken is dropped, software waits for free

  char_hold #(
    .W (9)
  ) u_tx_hold (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (wr_tx_data),
    .data_i ({tx_ctrl_q[`TXC_NINTH], pwdata_i[7:0]}),
    .take_i (tx_take),
    .data_o (tx_char_o),
    .full_o (tx_char_valid_o),
    .drop_o ()
  );

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_low_q   <= `RST_BYTE;
      div_high_q  <= `RST_BYTE;
      rx_ctrl_q   <= `RST_BYTE;
      tx_ctrl_q   <= `RST_BYTE;
      baud_ctrl_q <= `RST_BYTE;
      irq_en_q    <= {`IRQ_WIDTH{1'b0}};
      tx_last_q   <= `RST_BYTE;
    end else begin
      if (wr_div_low) begin
        div_low_q <= pwdata_i[7:0];
      end
      if (wr_div_high) begin
        div_high_q <= pwdata_i[7:0];
      end
      if (wr & (paddr_i == `OFS_RX_CTRL_STATUS)) begin
        rx_ctrl_q <= pwdata_i[7:0] & `RXC_WR_MASK;
      end
      if (wr & (paddr_i == `OFS_TX_CTRL_STATUS)) begin
        tx_ctrl_q <= pwdata_i[7:0] & `TXC_WR_MASK;
      end
      if (wr & (paddr_i == `OFS_BAUD_CONTROL)) begin
        baud_ctrl_q <= pwdata_i[7:0] & `BDC_WR_MASK;
      end
      if (wr & (paddr_i == `OFS_IRQ_ENABLE)) begin
        irq_en_q <= pwdata_i[`IRQ_WIDTH-1:0];
      end
      if (wr_tx_data) begin
        tx_last_q <= pwdata_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // receive error flags
  // --------------------------------------------------------------------------
  // overrun stays until continuous receive is switched off
  always @(posedge clk_i) begin
    if (rst_i) begin
      overrun_q   <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      if (rx_drop) begin
        overrun_q <= 1'b1;
      end else if (!rx_ctrl_q[`RXC_CONT_RX]) begin
        overrun_q <= 1'b0;
      end
      if (rx_load & ~rx_drop) begin
        frame_err_q <= rx_frame_err_i;
      end
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status
  // --------------------------------------------------------------------------
  wire [`IRQ_WIDTH-1:0] irq_event;
  wire [`IRQ_WIDTH-1:0] irq_clr;

  assign irq_event[`IRQ_RX_READY] = rx_load & ~rx_drop;
  assign irq_event[`IRQ_TX_FREE]  = tx_take;
  assign irq_event[`IRQ_OVERRUN]  = rx_drop;

  assign irq_clr = (wr & (paddr_i == `OFS_IRQ_CLEAR)) ?
                   pwdata_i[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  // a new event in the clearing cycle keeps its bit set
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= {`IRQ_WIDTH{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_event;
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    case (paddr_i)
      `OFS_RECEIVE_DATA:   rd_byte = rx_held[7:0];
      `OFS_TRANSMIT_DATA:  rd_byte = tx_last_q;
      `OFS_BAUD_DIV_LOW:   rd_byte = div_low_q;
      `OFS_BAUD_DIV_HIGH:  rd_byte = div_high_q;
      `OFS_RX_CTRL_STATUS: rd_byte = {rx_ctrl_q[7:3], frame_err_q, overrun_q,
                                      rx_held[8]};
      `OFS_TX_CTRL_STATUS: rd_byte = {tx_ctrl_q[7:2], tx_shift_empty_i,
                                      tx_ctrl_q[0]};
      `OFS_BAUD_CONTROL:   rd_byte = {baud_ctrl_q[7], rx_idle_i, baud_ctrl_q[5:0]};
      `OFS_IRQ_STATUS:     rd_byte = {{(8-`IRQ_WIDTH){1'b0}}, irq_stat_q};
      `OFS_IRQ_ENABLE:     rd_byte = {{(8-`IRQ_WIDTH){1'b0}}, irq_en_q};
      default:             rd_byte = 8'h00;
    endcase
  end

  // captured in the setup cycle, so it stands through the access cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= {24'h000000, rd_byte};
    end
  end

  // --------------------------------------------------------------------------
  // receive read arming
  // --------------------------------------------------------------------------
  // the read word is latched in the setup cycle, so only a character already
  // held then may be released at the access edge; one that lands in the
  // setup cycle itself stays held for the next read instead of being lost
  // without an overrun
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_armed_q <= 1'b0;
    end else begin
      rx_armed_q <= psel_i & ~penable_i & ~pwrite_i &
                    (paddr_i == `OFS_RECEIVE_DATA) & rx_full;
    end
  end

endmodule

`default_nettype wire

// >>> pkg/uart_baud_regs.vh
// Purpose: register map, field positions and reset values of the serial port data/baud block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   bits above bit 7 of every register read as zero
`ifndef UART_BAUD_REGS_VH
`define UART_BAUD_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_RECEIVE_DATA     8'h00
`define OFS_TRANSMIT_DATA    8'h04
`define OFS_BAUD_DIV_LOW     8'h08
`define OFS_BAUD_DIV_HIGH    8'h0C
`define OFS_RX_CTRL_STATUS   8'h10
`define OFS_TX_CTRL_STATUS   8'h14
`define OFS_BAUD_CONTROL     8'h18
`define OFS_IRQ_STATUS       8'h1C
`define OFS_IRQ_CLEAR        8'h20
`define OFS_IRQ_ENABLE       8'h24

// ----------------------------------------------------------------------------
// receive control/status fields
// ----------------------------------------------------------------------------
`define RXC_PORT_EN          7
`define RXC_NINE_BIT         6
`define RXC_SINGLE_RX        5
`define RXC_CONT_RX          4
`define RXC_ADDR_DET         3
`define RXC_FRAME_ERR        2
`define RXC_OVERRUN          1
`define RXC_NINTH            0
`define RXC_WR_MASK          8'hF8

// ----------------------------------------------------------------------------
// transmit control/status fields
// ----------------------------------------------------------------------------
`define TXC_CLK_MASTER       7
`define TXC_NINE_BIT         6
`define TXC_TX_EN            5
`define TXC_SYNC_MODE        4
`define TXC_SEND_BREAK       3
`define TXC_HIGH_SPEED       2
`define TXC_SHIFT_EMPTY      1
`define TXC_NINTH            0
`define TXC_WR_MASK          8'hFD

// ----------------------------------------------------------------------------
// baud control fields
// ----------------------------------------------------------------------------
`define BDC_RX_IDLE          6
`define BDC_WIDE_DIV         3
`define BDC_WR_MASK          8'h9B

// ----------------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------------
`define IRQ_RX_READY         0
`define IRQ_TX_FREE          1
`define IRQ_OVERRUN          2
`define IRQ_WIDTH            3

// ----------------------------------------------------------------------------
// reset values and prescale factors
// ----------------------------------------------------------------------------
`define RST_BYTE             8'h00
`define PRESCALE_SLOW        7'h40
`define PRESCALE_MID         7'h10
`define PRESCALE_FAST        7'h04

`endif

// >>> testbench/shifter_model.sv
// Purpose: behavioural receive and transmit shifters facing the block
// Assumes: same clock as the block
// Notes:   transmit shift takes 20 cycles, so a second char must wait held
`timescale 1ns/10ps
`default_nettype none
module shifter_model (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // receive side
  output logic            rx_char_valid_o,
  output logic [8:0]      rx_char_o,
  output logic            rx_frame_err_o,
  output logic            rx_idle_o,
  // transmit side
  input wire logic        tx_char_valid_i,
  input wire logic [8:0]  tx_char_i,
  output logic            tx_char_ready_o,
  output logic            tx_shift_empty_o
);
  logic [8:0] got[$];
  int busy = 0;
  initial begin
    rx_char_valid_o = 1'b0;
    rx_char_o = 9'h000;
    rx_frame_err_o = 1'b0;
    rx_idle_o = 1'b1;
  end
  assign tx_char_ready_o = (busy == 0);
  assign tx_shift_empty_o = (busy == 0);
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 0;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end else if (tx_char_valid_i) begin
      got.push_back(tx_char_i);
      busy <= 20;
    end
  end
  // char bits are only valid with the pulse; inverted after so stale data is not trusted
  task send(input logic [8:0] c);
    @(posedge clk_i);
    rx_idle_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    rx_char_o <= c;
    rx_char_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_char_valid_o <= 1'b0;
    rx_char_o <= ~c;
    rx_idle_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_uart_baud_and_data_regs.sv
// Purpose: self-checking bench for the serial data/baud register block
// Assumes: zero-wait apb slave, 125 MHz clock
// Notes:   baud cases run real divisors, so long ones take thousands of cycles
`timescale 1ns/10ps
`default_nettype none
module tb_uart_baud_and_data_regs;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] rd;
  logic        err;
  wire logic [31:0] prdata_o;
  wire logic        pready_o, pslverr_o, rx_v, rx_fe, rx_idle, tx_v, tx_rdy, tx_empty, irq_o;
  wire logic [8:0]  rx_c, tx_c;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int k;
  always #4 clk_i = ~clk_i;
  shifter_model m (.clk_i(clk_i), .rst_i(rst_i), .rx_char_valid_o(rx_v), .rx_char_o(rx_c),
    .rx_frame_err_o(rx_fe), .rx_idle_o(rx_idle), .tx_char_valid_i(tx_v), .tx_char_i(tx_c),
    .tx_char_ready_o(tx_rdy), .tx_shift_empty_o(tx_empty));
  uart_baud_and_data_regs dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .rx_char_valid_i(rx_v),
    .rx_char_i(rx_c), .rx_frame_err_i(rx_fe), .rx_idle_i(rx_idle), .tx_char_valid_o(tx_v),
    .tx_char_o(tx_c), .tx_char_ready_i(tx_rdy), .tx_shift_empty_i(tx_empty), .baud_tick_o(),
    .sync_mode_o(), .port_enable_o(), .tx_enable_o(), .rx_enable_o(), .clk_master_o(),
    .tx_nine_bit_o(), .rx_nine_bit_o(), .irq_o(irq_o));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, mask, input string what);
    apb(1'b0, a, 32'h00000000);
    chk(what, exp, rd & mask);
  endtask
  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (dut.baud_tick_o !== 1'b1 && n < 5000);
  endtask
  task reset_test;
    for (int i = 0; i < 4; i++) rdc(8'(i * 4), 32'h0, 32'hFFFFFFFF, "reset_value");
  endtask
  task rx_test;
    apb(1'b1, 8'h10, 32'h00000090);
    m.send(9'h1A5);
    apb(1'b1, 8'h24, 32'h00000001);
    #1 chk("irq_raised", 32'h1, {31'h0, irq_o});
    rdc(8'h10, 32'h1, 32'h1, "rx_ninth");
    fork
      m.send(9'h05A);
      rdc(8'h00, 32'hA5, 32'hFFFFFFFF, "rx_low_byte");
    join
    rdc(8'h00, 32'h5A, 32'hFF, "rx_next");
    rdc(8'h10, 32'h0, 32'h1, "rx_ninth_next");
    m.send(9'h0C3);
    m.send(9'h03C);
    rdc(8'h1C, 32'h5, 32'h5, "irq_overrun");
    rdc(8'h00, 32'hC3, 32'hFF, "rx_kept");
    apb(1'b1, 8'h24, 32'h00000000);
    #1 chk("irq_masked", 32'h0, {31'h0, irq_o});
    apb(1'b1, 8'h20, 32'h00000007);
    rdc(8'h1C, 32'h0, 32'h5, "irq_cleared");
    apb(1'b0, 8'h28, 32'h00000000);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
  endtask
  task tx_test;
    apb(1'b1, 8'h14, 32'h00000021);
    apb(1'b1, 8'h04, 32'h0000003C);
    apb(1'b1, 8'h04, 32'h000000C3);
    #1 chk("tx_held", 32'h3C3, {22'h0, tx_v, tx_c});
    rdc(8'h14, 32'h21, 32'hFF, "tx_status_busy");
    k = 0;
    while (m.got.size() < 2 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    chk("tx_count", 32'd2, m.got.size());
    chk("tx_first", 32'h13C, {23'h0, m.got[0]});
    chk("tx_second", 32'h1C3, {23'h0, m.got[1]});
    rdc(8'h04, 32'hC3, 32'hFF, "tx_readback");
  endtask
  // p is the prescale of the mode; the high byte counts only with the wide select
  task baud_case(input logic [7:0] txc, bdc, lo, hi, input int p);
    int per;
    per = p * ((bdc[3] ? {hi, lo} : {8'h00, lo}) + 1);
    apb(1'b1, 8'h14, {24'h0, txc});
    apb(1'b1, 8'h18, {24'h0, bdc});
    apb(1'b1, 8'h08, {24'h0, lo});
    apb(1'b1, 8'h0C, {24'h0, hi});
    wait_tick(k);
    chk("first_tick_high", per, k);
    apb(1'b1, 8'h08, {24'h0, lo});
    wait_tick(k);
    chk("first_tick_low", per, k);
    wait_tick(k);
    chk("tick_period", per, k);
  endtask
  task baud_test;
    baud_case(8'h20, 8'h00, 8'h02, 8'h05, 64);
    baud_case(8'h24, 8'h00, 8'h02, 8'h05, 16);
    baud_case(8'h20, 8'h08, 8'h02, 8'h01, 16);
    baud_case(8'h24, 8'h08, 8'h02, 8'h01, 4);
    baud_case(8'hB4, 8'h00, 8'h02, 8'h05, 4);
    baud_case(8'hB0, 8'h00, 8'h02, 8'h05, 4);
    baud_case(8'hB0, 8'h08, 8'h02, 8'h01, 4);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ceiling well above the roughly 20000 cycles the baud cases need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_test;
    rx_test;
    tx_test;
    baud_test;
    stop_test;
  end
endmodule
`default_nettype wire

// >>> testbench/uart_baud_and_data_regs_properties.sv
// Purpose: port-level assertions for the serial data/baud register block
// Assumes: single clock, synchronous active-high reset
// Notes:   sees only top-level ports, attached by bind
`timescale 1ns/10ps
`default_nettype none
module uart_regs_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  // shifter side
  input wire logic        tx_char_valid_o,
  input wire logic [8:0]  tx_char_o,
  input wire logic        tx_char_ready_i,
  input wire logic        baud_tick_o,
  input wire logic        sync_mode_o,
  input wire logic        port_enable_o,
  input wire logic        tx_enable_o,
  input wire logic        rx_enable_o,
  input wire logic        clk_master_o,
  input wire logic        tx_nine_bit_o,
  input wire logic        rx_nine_bit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr_tx = psel_i & penable_i & pwrite_i & (paddr_i == 8'h04);
  wire wr_div = psel_i & penable_i & pwrite_i & ((paddr_i == 8'h08) | (paddr_i == 8'h0C));
  a_ready_const: assert property (pready_o) else $error("pready low");
  a_err_unmapped: assert property (psel_i && penable_i && paddr_i > 8'h24 |-> pslverr_o)
    else $error("no error on unmapped address");
  a_rdata_upper: assert property (prdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_tx_load: assert property (wr_tx |=> tx_char_valid_o && tx_char_o[7:0] == $past(pwdata_i[7:0]))
    else $error("transmit write not held");
  a_tx_hold: assert property (tx_char_valid_o && !tx_char_ready_i && !wr_tx |=>
    tx_char_valid_o && $stable(tx_char_o)) else $error("held char lost");
  a_tx_taken: assert property (tx_char_valid_o && tx_char_ready_i && !wr_tx |=> !tx_char_valid_o)
    else $error("char not released after take");
  a_div_restart: assert property (wr_div |=> !baud_tick_o [*4])
    else $error("tick too soon after divisor write");
  a_tick_single: assert property (baud_tick_o |=> !baud_tick_o [*3])
    else $error("ticks closer than four cycles");
  a_tick_idle: assert property (!port_enable_o && $past(!port_enable_o) |-> !baud_tick_o)
    else $error("tick while port disabled");
  a_sync_map: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h14 |=>
    sync_mode_o == $past(pwdata_i[4])) else $error("sync mode not from bit 4");
  a_tx_cfg_map: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h14 |=>
    {clk_master_o, tx_nine_bit_o, tx_enable_o} == $past(pwdata_i[7:5]))
    else $error("transmit control outputs not from bits 7 to 5");
  a_rx_cfg_map: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h10 |=>
    {port_enable_o, rx_nine_bit_o} == $past(pwdata_i[7:6]) &&
    rx_enable_o == ($past(pwdata_i[5]) || $past(pwdata_i[4])))
    else $error("receive control outputs wrong");
endmodule
bind uart_baud_and_data_regs uart_regs_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .tx_char_valid_o(tx_char_valid_o), .tx_char_o(tx_char_o),
  .tx_char_ready_i(tx_char_ready_i), .baud_tick_o(baud_tick_o), .sync_mode_o(sync_mode_o),
  .port_enable_o(port_enable_o), .tx_enable_o(tx_enable_o), .rx_enable_o(rx_enable_o),
  .clk_master_o(clk_master_o), .tx_nine_bit_o(tx_nine_bit_o), .rx_nine_bit_o(rx_nine_bit_o));
`default_nettype wire
